/* File: hw/rocof_stage.sv */
// Purpose: Eight-stage rocof_stage protection with events and operation records
// Assumes: Measurements and block inputs synchronous to SYS_CLK
// Notes:   Stages are scanned one at a time after each 5 ms tick
`timescale 1ns/1ps
`include "rocof_defs.svh"

// Function
// (R1) Block input sampled once at each processing cycle start, used all cycle.
// (R2) Block comes from a dedicated input fed by the blocking matrix.
// (R3) Pick-up without block asserts START and runs the operate delay.
// (R4) Pick-up with block asserts BLOCKED instead; nothing further done.
// (R5) Block after START clears START; release as on pick-up drop-out.
// (R6) Blocking raises a notification and time-stamped event with frequency data.
// (R7) Block source must assert 5 ms before the operate delay expires.
// (R8) In forcing test mode a software switch drives the block input.
// (R9) START-to-TRIP and release use definite time only.
// (R10) Every START, TRIP, BLOCKED change makes an event and record update; the code writes a record only on ON changes.
// (R11) Per event type, ON, OFF or both are written to the buffer.
// (R12) Each event carries a time stamp and process data.
// (R13) Each stage has six own event codes under one common source.
// (R14) The last 12 time-stamped operation records are kept.
// (R15) Record: time, event, pre-trigger rocof_stage and f, fault values, group.
// (R16) Status code: 0 normal, 1 started, 2 tripped, 3 blocked.
// (R17) Measured rocof_stage magnitude reported in mHz/s.
// (R18) Ratio of rocof_stage to pick-up reported in steps of 0.005 pu.
// (R19) Expected operating time reported in 5 ms steps.
// (R20) Remaining time to trip reported in 5 ms steps.
// (R21) Drop-out threshold lies 100 mHz/s below pick-up.
// (R22) Direction setting allows rising, falling or both.
// (R23) Stage blocked while rocof_stage exceeds the maximum allowed rate.
// (R24) Measurements refreshed on a 5 ms time base.
// (R25) A full record store overwrites its oldest entry.
module rocof_stage
#(
  parameter int unsigned NUM_STAGES  = 8,
  parameter int unsigned NUM_RECORDS = 12,
  parameter int unsigned TICK_CYCLES = `RC_TICK_CYCLES
)
(
  input  wire logic                     SYS_CLK,
  input  wire logic                     SYS_RST,
  input  wire logic signed [15:0]       MEAS_DFDT,
  input  wire logic        [15:0]       MEAS_FREQ,
  input  wire logic        [31:0]       TIME_MS,
  input  wire logic        [2:0]        SETTING_GROUP,
  input  wire logic [NUM_STAGES-1:0]    BLOCK_IN,
  input  wire logic        [7:0]        REG_ADDR,
  input  wire logic        [31:0]       REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  output      logic        [31:0]       REG_RDATA,
  output      logic [NUM_STAGES-1:0]    START_OUT,
  output      logic [NUM_STAGES-1:0]    TRIP_OUT,
  output      logic [NUM_STAGES-1:0]    BLOCKED_OUT,
  output      logic                     EVT_VALID,
  output      rocof_pkg::evt_s          EVT_DATA
);

  localparam int IW  = (NUM_STAGES > 1) ? $clog2(NUM_STAGES) : 1;
  localparam int RW  = $clog2(NUM_RECORDS);
  localparam int PRE = `RC_PRE_TICKS;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers for write decode and read-back; status_code serves read-back only
  function automatic logic stage_hit(input logic [7:0] a);
    return (a[7:4] != 4'h0) && (32'(a[7:4]) <= NUM_STAGES);
  endfunction : stage_hit

  function automatic logic [IW-1:0] stage_ix(input logic [7:0] a);
    return IW'(a[7:4] - 4'h1);
  endfunction : stage_ix

  function automatic logic [1:0] status_code(input logic st, input logic tr,
                                             input logic bl);
    return tr ? `RC_STAT_TRIP : st ? `RC_STAT_START :
           bl ? `RC_STAT_BLOCKED : `RC_STAT_NORMAL;
  endfunction : status_code

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0]              tick_cnt_q, tick_cnt_d;
  logic                     tick_q, tick_d;
  logic [NUM_STAGES-1:0]    blk_smp_q, blk_smp_d;
  rocof_pkg::meas_s         samp_q, samp_d;
  rocof_pkg::meas_s         hist_q [PRE];
  rocof_pkg::meas_s         hist_d [PRE];
  logic [31:0]              time_q, time_d;
  logic [2:0]               sg_q, sg_d;
  logic                     force_en_q, force_en_d;
  logic [NUM_STAGES-1:0]    soft_blk_q, soft_blk_d;
  logic [15:0]              maxrate_q, maxrate_d;
  logic [5:0]               evmask_q, evmask_d;
  logic [RW-1:0]            rec_sel_q, rec_sel_d;
  logic [15:0]              pickup_q [NUM_STAGES];
  logic [15:0]              pickup_d [NUM_STAGES];
  logic [1:0]               mode_q [NUM_STAGES];
  logic [1:0]               mode_d [NUM_STAGES];
  logic [18:0]              delay_q [NUM_STAGES];
  logic [18:0]              delay_d [NUM_STAGES];
  logic [NUM_STAGES-1:0]    en_q, en_d;
  rocof_pkg::seq_e          seq_q, seq_d;
  logic [IW-1:0]            idx_q, idx_d;
  logic [1:0]               typ_q, typ_d;
  logic [NUM_STAGES-1:0]    start_q, start_d, trip_q, trip_d;
  logic [NUM_STAGES-1:0]    blkd_q, blkd_d;
  logic [18:0]              remain_q [NUM_STAGES];
  logic [18:0]              remain_d [NUM_STAGES];
  logic [15:0]              ratio_q [NUM_STAGES];
  logic [15:0]              ratio_d [NUM_STAGES];
  logic [2:0]               old_q, old_d, new_q, new_d;
  logic [15:0]              mag, thr;
  logic                     dir_ok, pu, blk, n_start;
  logic [18:0]              rem_n;
  logic [23:0]              quot;
  logic                     evt_valid_q, evt_valid_d;
  rocof_pkg::evt_s          evt_q, evt_d;
  rocof_pkg::rec_s          rec_q [NUM_RECORDS];
  rocof_pkg::rec_s          rec_d [NUM_RECORDS];
  logic [RW-1:0]            wptr_q, wptr_d;
  logic [RW:0]              count_q, count_d;
  logic                     chg, on;
  logic [2:0]               mix;
  logic [7:0]               code;
  logic [31:0]              rdata_q, rdata_d;

  // Magnitude is shared by comparator, ratio and read-back
  assign mag = samp_q.dfdt[15] ? 16'(-samp_q.dfdt) : 16'(samp_q.dfdt);

  ////////////////////////////////////////////////////////////////////////////
  // Processing-cycle tick and input sampling
  // Block lines latch only on the tick so a mid-scan change cannot split
  // one cycle's decisions across two block values.
  always_comb
  begin
    tick_d     = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    tick_cnt_d = tick_d ? 32'h0 : tick_cnt_q + 32'h1;       // see (R24)
    blk_smp_d  = tick_q ? BLOCK_IN : blk_smp_q;             // see (R1) (R2)
    samp_d     = samp_q;
    hist_d     = hist_q;
    time_d     = time_q;
    sg_d       = sg_q;
    if (tick_q)
    begin
      samp_d = {MEAS_DFDT, MEAS_FREQ};                      // see (R24)
      time_d = TIME_MS;
      sg_d   = SETTING_GROUP;
      hist_d[0] = samp_q;                                   // see (R15)
      for (int k = 1; k < PRE; k++)
        hist_d[k] = hist_q[k-1];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
      blk_smp_q  <= '0;
      samp_q     <= '0;
      hist_q     <= '{default: '0};
      time_q     <= 32'h0;
      sg_q       <= 3'h0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
      blk_smp_q  <= blk_smp_d;
      samp_q     <= samp_d;
      hist_q     <= hist_d;
      time_q     <= time_d;
      sg_q       <= sg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration writes
  always_comb
  begin
    force_en_d = force_en_q;
    soft_blk_d = soft_blk_q;
    maxrate_d  = maxrate_q;
    evmask_d   = evmask_q;
    rec_sel_d  = rec_sel_q;
    pickup_d   = pickup_q;
    mode_d     = mode_q;
    delay_d    = delay_q;
    en_d       = en_q;
    if (REG_WR && stage_hit(REG_ADDR))
    begin
      case (REG_ADDR[3:0])
        `RC_FLD_PICKUP: pickup_d[stage_ix(REG_ADDR)] = REG_WDATA[15:0];
        `RC_FLD_MODE:
        begin
          mode_d[stage_ix(REG_ADDR)] = REG_WDATA[1:0];       // see (R22)
          en_d[stage_ix(REG_ADDR)]   = REG_WDATA[`RC_MODE_EN];
        end
        `RC_FLD_DELAY:  delay_d[stage_ix(REG_ADDR)] = REG_WDATA[18:0];
        default: ;
      endcase
    end
    else if (REG_WR && REG_ADDR[7:4] == 4'h0)
    begin
      case (REG_ADDR[3:0])
        `RC_REG_CTRL:
        begin
          force_en_d = REG_WDATA[`RC_CTRL_FORCE];
          soft_blk_d = REG_WDATA[`RC_CTRL_SOFTBLK +: NUM_STAGES];
        end
        `RC_REG_MAXRATE: maxrate_d = REG_WDATA[15:0];
        `RC_REG_EVMASK:  evmask_d  = REG_WDATA[5:0];
        `RC_REG_RECSEL:
          if (REG_WDATA < 32'(NUM_RECORDS))                 // Out of range ignored
            rec_sel_d = REG_WDATA[RW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      force_en_q <= 1'b0;
      soft_blk_q <= '0;
      maxrate_q  <= `RC_MAXRATE_RST;
      evmask_q   <= `RC_EVMASK_RST;
      rec_sel_q  <= '0;
      pickup_q   <= '{default: `RC_PICKUP_RST};
      mode_q     <= '{default: `RC_MODE_RST};
      delay_q    <= '{default: `RC_DELAY_RST};
      en_q       <= '0;
    end
    else
    begin
      force_en_q <= force_en_d;
      soft_blk_q <= soft_blk_d;
      maxrate_q  <= maxrate_d;
      evmask_q   <= evmask_d;
      rec_sel_q  <= rec_sel_d;
      pickup_q   <= pickup_d;
      mode_q     <= mode_d;
      delay_q    <= delay_d;
      en_q       <= en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage scan: one EVAL cycle then three EMIT cycles per stage
  always_comb
  begin
    seq_d    = seq_q;
    idx_d    = idx_q;
    typ_d    = typ_q;
    start_d  = start_q;
    trip_d   = trip_q;
    blkd_d   = blkd_q;
    remain_d = remain_q;
    ratio_d  = ratio_q;
    old_d    = old_q;
    new_d    = new_q;
    case (mode_q[idx_q])                                    // see (R22)
      2'h0:    dir_ok = !samp_q.dfdt[15] && (mag != 16'h0);
      2'h1:    dir_ok = samp_q.dfdt[15];
      2'h2:    dir_ok = 1'b1;
      default: dir_ok = 1'b0;
    endcase
    // Drop-out level sits below pick-up once the stage is active
    thr = (start_q[idx_q] || blkd_q[idx_q]) ?
          ((pickup_q[idx_q] > `RC_HYST_MHZS) ?
           pickup_q[idx_q] - `RC_HYST_MHZS : 16'h0) :
          pickup_q[idx_q];                                  // see (R21)
    pu  = en_q[idx_q] && dir_ok && (mag >= thr);
    blk = (force_en_q ? soft_blk_q[idx_q] : blk_smp_q[idx_q]) // see (R8)
          || (mag > maxrate_q);                             // see (R23)
    n_start = pu && !blk;                                   // see (R3) (R4) (R5)
    // Fixed delay only: load on start, count one per tick, clear on release
    rem_n = !n_start ? 19'h0 :
            !start_q[idx_q] ? delay_q[idx_q] :
            (remain_q[idx_q] != 19'h0) ? remain_q[idx_q] - 19'h1 :
            19'h0;                                          // see (R9)
    quot = (pickup_q[idx_q] == 16'h0) ? 24'h0 :
           (24'(mag) * `RC_RATIO_STEPS) / 24'(pickup_q[idx_q]);
    case (seq_q)
      rocof_pkg::SEQ_IDLE:
        if (tick_q)
        begin
          seq_d = rocof_pkg::SEQ_EVAL;
          idx_d = '0;
        end
      rocof_pkg::SEQ_EVAL:
      begin
        old_d = {blkd_q[idx_q], trip_q[idx_q], start_q[idx_q]};
        start_d[idx_q]  = n_start;
        trip_d[idx_q]   = n_start && (rem_n == 19'h0);
        blkd_d[idx_q]   = pu && blk;                        // see (R4)
        remain_d[idx_q] = rem_n;                            // see (R20)
        ratio_d[idx_q]  = (quot[23:16] != 8'h0) ? 16'hffff : quot[15:0];
        new_d = {pu && blk, n_start && (rem_n == 19'h0), n_start};
        seq_d = rocof_pkg::SEQ_EMIT;
        typ_d = 2'h0;
      end
      rocof_pkg::SEQ_EMIT:
        if (typ_q == 2'h2)
        begin
          if (idx_q == IW'(NUM_STAGES - 1))
            seq_d = rocof_pkg::SEQ_IDLE;
          else
          begin
            idx_d = idx_q + IW'(1);
            seq_d = rocof_pkg::SEQ_EVAL;
          end
        end
        else
          typ_d = typ_q + 2'h1;
      default: seq_d = rocof_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      seq_q    <= rocof_pkg::SEQ_IDLE;
      idx_q    <= '0;
      typ_q    <= 2'h0;
      start_q  <= '0;
      trip_q   <= '0;
      blkd_q   <= '0;
      remain_q <= '{default: '0};
      ratio_q  <= '{default: '0};
      old_q    <= 3'h0;
      new_q    <= 3'h0;
    end
    else
    begin
      seq_q    <= seq_d;
      idx_q    <= idx_d;
      typ_q    <= typ_d;
      start_q  <= start_d;
      trip_q   <= trip_d;
      blkd_q   <= blkd_d;
      remain_q <= remain_d;
      ratio_q  <= ratio_d;
      old_q    <= old_d;
      new_q    <= new_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and records, one output type per EMIT cycle so none collide
  always_comb
  begin
    chg  = (seq_q == rocof_pkg::SEQ_EMIT) && (old_q[typ_q] != new_q[typ_q]);
    on   = new_q[typ_q];
    mix  = {typ_q, !on};                                    // Type*2 + off
    code = 8'(8'(idx_q) * `RC_CODES_STAGE) + {5'h0, mix};   // see (R13)
    evt_valid_d = chg && evmask_q[mix];                     // see (R10) (R11)
    evt_d = evt_q;
    if (evt_valid_d)
      evt_d = '{src: `RC_EVT_SOURCE, code: code, time_ms: time_q,
                dfdt: samp_q.dfdt, freq: samp_q.freq, sg: sg_q}; // see (R6) (R12)
    rec_d   = rec_q;
    wptr_d  = wptr_q;
    count_d = count_q;
    if (chg && on)                                          // see (R10) (R14)
    begin
      rec_d[wptr_q] = '{time_ms: time_q, code: code, pre: hist_q[PRE-1],
                        flt: samp_q, sg: sg_q};             // see (R15)
      wptr_d = (wptr_q == RW'(NUM_RECORDS - 1)) ? '0 : wptr_q + RW'(1);
      if (count_q != (RW+1)'(NUM_RECORDS))                  // see (R25)
        count_d = count_q + (RW+1)'(1);
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      evt_valid_q <= 1'b0;
      evt_q       <= '0;
      rec_q       <= '{default: '0};
      wptr_q      <= '0;
      count_q     <= '0;
    end
    else
    begin
      evt_valid_q <= evt_valid_d;
      evt_q       <= evt_d;
      rec_q       <= rec_d;
      wptr_q      <= wptr_d;
      count_q     <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back; data stands only in the cycle after the strobe
  always_comb
  begin
    rdata_d = 32'h0;
    if (REG_RD && stage_hit(REG_ADDR))
    begin
      case (REG_ADDR[3:0])
        `RC_FLD_PICKUP: rdata_d = 32'(pickup_q[stage_ix(REG_ADDR)]);
        `RC_FLD_MODE:   rdata_d = {27'h0, en_q[stage_ix(REG_ADDR)], 2'h0,
                                   mode_q[stage_ix(REG_ADDR)]};
        `RC_FLD_DELAY:  rdata_d = 32'(delay_q[stage_ix(REG_ADDR)]);
        `RC_FLD_STATUS: rdata_d = 32'(status_code(start_q[stage_ix(REG_ADDR)],
                                   trip_q[stage_ix(REG_ADDR)],
                                   blkd_q[stage_ix(REG_ADDR)])); // see (R16)
        `RC_FLD_RATIO:  rdata_d = 32'(ratio_q[stage_ix(REG_ADDR)]); // see (R18)
        `RC_FLD_EXPECT: rdata_d = 32'(delay_q[stage_ix(REG_ADDR)]); // see (R19)
        `RC_FLD_REMAIN: rdata_d = 32'(remain_q[stage_ix(REG_ADDR)]); // see (R20)
        default: ;
      endcase
    end
    else if (REG_RD && REG_ADDR[7:4] == 4'h0)
    begin
      case (REG_ADDR[3:0])
        `RC_REG_CTRL:    rdata_d = 32'({soft_blk_q, 7'h0, force_en_q});
        `RC_REG_MAXRATE: rdata_d = 32'(maxrate_q);
        `RC_REG_EVMASK:  rdata_d = 32'(evmask_q);
        `RC_REG_DFDT:    rdata_d = 32'(mag);                // see (R17)
        `RC_REG_RECSEL:  rdata_d = 32'(rec_sel_q);
        `RC_REG_RECINFO: rdata_d = {8'h0, 8'(wptr_q), 8'h0, 8'(count_q)};
        `RC_REG_RECTIME: rdata_d = rec_q[rec_sel_q].time_ms;
        `RC_REG_RECCODE: rdata_d = {21'h0, rec_q[rec_sel_q].sg,
                                    rec_q[rec_sel_q].code};
        `RC_REG_RECPRE:  rdata_d = rec_q[rec_sel_q].pre;
        `RC_REG_RECFLT:  rdata_d = rec_q[rec_sel_q].flt;
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      rdata_q <= 32'h0;
    else
      rdata_q <= rdata_d;
  end

  // Outputs straight from flops
  assign REG_RDATA   = rdata_q;
  assign START_OUT   = start_q;
  assign TRIP_OUT    = trip_q;
  assign BLOCKED_OUT = blkd_q;
  assign EVT_VALID   = evt_valid_q;
  assign EVT_DATA    = evt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  blk_sample_hold_a : assert property (                     // see (R1)
    !tick_q |=> $stable(blk_smp_q)) else $error("block sample moved");
  start_vs_block_a : assert property (                      // see (R4)
    (start_q & blkd_q) == '0) else $error("start and blocked together");
  trip_needs_start_a : assert property (                    // see (R9)
    (trip_q & ~start_q) == '0) else $error("trip without start");
  evt_code_range_a : assert property (                      // see (R13)
    EVT_VALID |-> EVT_DATA.src == `RC_EVT_SOURCE &&
    32'(EVT_DATA.code) < NUM_STAGES * 6) else $error("bad event code");
  evt_mask_gate_a : assert property (                       // see (R11)
    EVT_VALID |-> evmask_q[EVT_DATA.code % 6]) else $error("masked event");
  rec_store_ptr_a : assert property (                       // see (R25)
    32'(wptr_q) < NUM_RECORDS && 32'(count_q) <= NUM_RECORDS)
    else $error("record pointer out of range");
  status_read_a : assert property (                         // see (R16)
    REG_RD && REG_ADDR == {4'h1, `RC_FLD_STATUS} && trip_q[0]
    |=> REG_RDATA == 32'(`RC_STAT_TRIP)) else $error("bad status code");
  tick_period_a : assert property (                         // see (R24)
    tick_q |-> ##1 !tick_q [*2]) else $error("tick too short");
  block_clears_start_a : assert property (                  // see (R5)
    seq_q == rocof_pkg::SEQ_EVAL && blk |=> !start_q[$past(idx_q)])
    else $error("start kept under block");

  trip_seen_c    : cover property (evt_valid_q && evt_q.code == 8'h02);
  blocked_seen_c : cover property ($rose(blkd_q[0]));
  rec_wrap_c     : cover property (count_q == (RW+1)'(NUM_RECORDS) &&
                                   chg && on);

endmodule : rocof_stage

/* File: hw/rocof_defs.svh */
// Purpose: Offsets, field positions, reset values and timing for rocof_stage
// Assumes: 250 MHz system clock, plain register port with word addresses
// Notes:   Definitions only; included by every file that needs them
`ifndef ROCOF_DEFS_SVH
`define ROCOF_DEFS_SVH

// Timing: processing cycle, clock period and pre-trigger look-back
`define RC_TICK_NS      5000000
`define RC_CLK_NS       4
`define RC_TICK_CYCLES  (`RC_TICK_NS / `RC_CLK_NS)
`define RC_PRE_NS       20000000
`define RC_PRE_TICKS    (`RC_PRE_NS / `RC_TICK_NS)

// Fixed constants of the stage
`define RC_HYST_MHZS    16'h0064
`define RC_RATIO_STEPS  24'h0000c8
`define RC_EVT_SOURCE   8'h5a
`define RC_CODES_STAGE  8'h06

// Status codes
`define RC_STAT_NORMAL  2'h0
`define RC_STAT_START   2'h1
`define RC_STAT_TRIP    2'h2
`define RC_STAT_BLOCKED 2'h3

// Page 0 registers (address bits 3:0, address bits 7:4 zero)
`define RC_REG_CTRL     4'h0
`define RC_REG_MAXRATE  4'h1
`define RC_REG_EVMASK   4'h2
`define RC_REG_DFDT     4'h3
`define RC_REG_RECSEL   4'h4
`define RC_REG_RECINFO  4'h5
`define RC_REG_RECTIME  4'h6
`define RC_REG_RECCODE  4'h7
`define RC_REG_RECPRE   4'h8
`define RC_REG_RECFLT   4'h9

// Stage pages: address bits 7:4 hold stage number plus one
`define RC_FLD_PICKUP   4'h0
`define RC_FLD_MODE     4'h1
`define RC_FLD_DELAY    4'h2
`define RC_FLD_STATUS   4'h3
`define RC_FLD_RATIO    4'h4
`define RC_FLD_EXPECT   4'h5
`define RC_FLD_REMAIN   4'h6

// Field positions
`define RC_CTRL_FORCE   0
`define RC_CTRL_SOFTBLK 8
`define RC_MODE_EN      4

// Reset values
`define RC_MAXRATE_RST  16'h4e20
`define RC_PICKUP_RST   16'h00c8
`define RC_DELAY_RST    19'h00014
`define RC_MODE_RST     2'h0
`define RC_EVMASK_RST   6'h3f

`endif

/* File: hw/rocof_pkg.sv */
// Purpose: Types shared by the rate-of-change-of-frequency stage
// Assumes: rocof_stage in mHz/s signed, frequency in 10 mHz units
// Notes:   Constants live in rocof_defs.svh
package rocof_pkg;

  // One measurement sample
  typedef struct packed {
    logic signed [15:0] dfdt;
    logic        [15:0] freq;
  } meas_s;

  // Event word towards the main event buffer
  typedef struct packed {
    logic [7:0]         src;
    logic [7:0]         code;
    logic [31:0]        time_ms;
    logic signed [15:0] dfdt;
    logic [15:0]        freq;
    logic [2:0]         sg;
  } evt_s;

  // One operation record
  typedef struct packed {
    logic [31:0]        time_ms;
    logic [7:0]         code;
    meas_s              pre;
    meas_s              flt;
    logic [2:0]         sg;
  } rec_s;

  // Scan sequencer
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_EVAL, SEQ_EMIT} seq_e;

endpackage : rocof_pkg

/* File: tb/meas_source.sv */
// Purpose: Frequency front end and blocking matrix model
// Assumes: Samples move only on the 5 ms boundary
// Notes:   Time stamp steps 5 ms per boundary
`timescale 1ns/1ps
module meas_source
#(parameter int unsigned TICK = 40)
(
  input  wire logic               clk,
  input  wire logic signed [15:0] dfdt_set,
  input  wire logic        [7:0]  blk_set,
  output logic signed      [15:0] dfdt,
  output logic             [15:0] freq,
  output logic             [31:0] time_ms,
  output logic             [7:0]  blk
);
  int unsigned cnt = 0;
  initial {dfdt, freq, time_ms, blk} = '0;
  //////////////////////////////////////////////////////////////////////////
  // Whole sample set moves at once, so no half-updated set is seen
  always @(posedge clk)
  begin
    cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    if (cnt == 0)
    begin
      dfdt    <= dfdt_set;
      freq    <= 16'h1388;
      time_ms <= time_ms + 32'h5;
      blk     <= blk_set;
    end
  end
endmodule : meas_source

/* File: tb/rocof_stage_test.sv */
// Purpose: Self-checking bench for rocof_stage
// Assumes: Short processing cycle of 40 clocks
// Notes:   Waits are bounded polls on the stage outputs
`timescale 1ns/1ps
`include "rocof_defs.svh"
module rocof_stage_test;
  logic clk = 0, rst = 1, wr = 0, rd = 0;
  logic [5:0] seen = '0;
  logic [7:0] addr = '0, blk_set = '0, blk, start, trip, blkd;
  logic [31:0] wdata = '0, rdata, tms, r;
  logic signed [15:0] dfdt_set = '0, dfdt;
  logic [15:0] freq;
  logic ev_valid;
  rocof_pkg::evt_s ev;
  int fails = 0, n_compared = 0, i;
  meas_source #(.TICK(40)) fe (.clk(clk), .dfdt_set(dfdt_set),
    .blk_set(blk_set), .dfdt(dfdt), .freq(freq), .time_ms(tms), .blk(blk));
  rocof_stage #(.TICK_CYCLES(40)) uut (.SYS_CLK(clk), .SYS_RST(rst),
    .MEAS_DFDT(dfdt), .MEAS_FREQ(freq), .TIME_MS(tms),
    .SETTING_GROUP(3'h2), .BLOCK_IN(blk), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .START_OUT(start), .TRIP_OUT(trip), .BLOCKED_OUT(blkd),
    .EVT_VALID(ev_valid), .EVT_DATA(ev));
  //////////////////////////////////////////////////////////////////////////
  initial forever #2 clk = ~clk;
  // Stage 0 event codes seen, each only with the common source
  always @(posedge clk)
    if (ev_valid === 1'b1 && ev.code < 8'h06)
      seen[ev.code[2:0]] <= (ev.src === `RC_EVT_SOURCE);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic t_reset;
    rd_reg(8'h10, r);
    chk(r, 32'h000000c8);
    rd_reg(8'h0f, r);
    chk(r, 32'h0);
    rd_reg(8'h13, r);
    chk(r, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_trip;
    wr_reg(8'h12, 32'h2);
    wr_reg(8'h11, 32'h10);
    dfdt_set <= 16'sd500;
    for (i = 0; i < 200 && start[0] !== 1'b1; i++) @(posedge clk);
    rd_reg(8'h13, r);
    chk(r, 32'h1);
    rd_reg(8'h16, r);
    chk(r, 32'h2);
    rd_reg(8'h15, r);
    chk(r, 32'h2);
    repeat (50) @(posedge clk);
    chk({31'h0, trip[0]}, 32'h0);
    for (i = 0; i < 80 && trip[0] !== 1'b1; i++) @(posedge clk);
    rd_reg(8'h13, r);
    chk(r, 32'h2);
    rd_reg(8'h03, r);
    chk(r, 32'h1f4);
    rd_reg(8'h14, r);
    chk(r, 32'h1f4);
    // Start on and trip on so far: two records, slot 0 is start on
    rd_reg(8'h05, r);
    chk(r, 32'h00020002);
    rd_reg(8'h07, r);
    chk(r, 32'h00000200);
    rd_reg(8'h09, r);
    chk(r, 32'h01f41388);
    $display("trip test done");
  endtask : t_trip
  task automatic t_block;
    blk_set <= 8'h01;
    for (i = 0; i < 200 && blkd[0] !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk({29'h0, blkd[0], start[0], trip[0]}, 32'h4);
    rd_reg(8'h13, r);
    chk(r, 32'h3);
    chk({31'h0, seen[4]}, 32'h1);
    blk_set <= 8'h00;
    for (i = 0; i < 200 && blkd[0] !== 1'b0; i++) @(posedge clk);
    chk({30'h0, blkd[0], start[0]}, 32'h1);
    wr_reg(8'h00, 32'h101);
    for (i = 0; i < 200 && blkd[0] !== 1'b1; i++) @(posedge clk);
    chk({31'h0, blkd[0]}, 32'h1);
    // All six stage 0 codes have occurred by now
    chk({26'h0, seen}, 32'h3f);
    $display("block test done");
  endtask : t_block
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////
  // Main sequence after ten reset cycles
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_trip();
    t_block();
    report_and_stop();
  end
  // Whole run needs about 260 clocks
  initial
  begin
    #100000;
    fails++;
    report_and_stop();
  end
endmodule : rocof_stage_test
